// ### common/cipg_defines.svh
// Purpose: offsets, field positions, reset values for the priority gate
// Assumes: 32-bit AHB-Lite register words
// Notes:   included by bare name
`ifndef CIPG_DEFINES_SVH
`define CIPG_DEFINES_SVH

// ==========================================================
// register offsets
`define CIPG_OFS_CTRL       8'h00
`define CIPG_OFS_BASE       8'h04
`define CIPG_OFS_SAVED      8'h08
`define CIPG_OFS_NODE0      8'h10

// ==========================================================
// field positions
`define CIPG_CTRL_IE_BIT    8
`define CIPG_CTRL_PENDING_PRIORITY_NUMBER_LSB  16
`define CIPG_SAVED_PIE_BIT  8
`define CIPG_NODE_EN_BIT    10
`define CIPG_NODE_REQ_BIT   24
`define CIPG_NODE_CLR_BIT   25
`define CIPG_NODE_SET_BIT   26

// ==========================================================
// values
`define CIPG_VEC_SHIFT      5
`define CIPG_PRIO_MAX       8'hff
`define CIPG_PRIO_NONE      8'h00
`define CIPG_NUM_SW_NODES   4
`define CIPG_BASE_RESET     32'h0000_0000
`define CIPG_BASE_MASK      32'hffff_fffe

`endif

// ### common/cipg_pkg.sv
// Purpose: shared types of the priority gate
// Assumes: nothing
// Notes:   constants live in cipg_defines.svh
package cipg_pkg;

    // ======================================================
    // arbitration phases
    typedef enum logic [1:0] {
        ARB_IDLE,
        ARB_CLEAR,
        ARB_LOAD
    } cipg_arb_e;

    typedef logic [7:0] cipg_prio_t;

endpackage : cipg_pkg

// ### rtl/cipg_node.sv
// Purpose: one service request node (flag, priority, enable)
// Assumes: write strobe and data valid in the same cycle
// Notes:   set beats clear when both arrive together
`include "cipg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cipg_node
    import cipg_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        hw_set_i,
    input  wire logic        take_clr_i,
    input  wire logic        wr_i,
    input  wire logic [31:0] wdata_i,
    output cipg_prio_t       prio_o,
    output logic             en_o,
    output logic             req_o
);

    // ======================================================
    // state
    typedef struct packed {
        cipg_prio_t prio;
        logic       en;
        logic       req;
    } cipg_node_s;

    cipg_node_s st_q;
    cipg_node_s st_d;
    logic       set_w;
    logic       clr_w;

    always_comb
    begin
        st_d  = st_q;
        set_w = hw_set_i | (wr_i & wdata_i[`CIPG_NODE_SET_BIT]);
        clr_w = take_clr_i | (wr_i & wdata_i[`CIPG_NODE_CLR_BIT]);
        if (wr_i)
        begin
            st_d.prio = wdata_i[7:0];
            st_d.en   = wdata_i[`CIPG_NODE_EN_BIT];
        end
        // late event must not vanish under a clear
        if (set_w)
            st_d.req = 1'b1;
        else if (clr_w)
            st_d.req = 1'b0;
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign prio_o = st_q.prio;
    assign en_o   = st_q.en;
    assign req_o  = st_q.req;

endmodule : cipg_node

`default_nettype wire

// ### rtl/cipg_arb.sv
// Purpose: pick the pending node with the highest priority number
// Assumes: priority zero never requests
// Notes:   ties go to the lowest node index
`include "cipg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cipg_arb
    import cipg_pkg::*;
#(
    parameter int N  = 8,
    parameter int IW = 3
)
(
    input  wire logic [N-1:0]   pend_i,
    input  wire logic [N*8-1:0] prio_i,
    output cipg_prio_t          win_prio_o,
    output logic [IW-1:0]       win_idx_o
);

    // ======================================================
    // linear max search, fine for a handful of nodes
    always_comb
    begin
        win_prio_o = `CIPG_PRIO_NONE;
        win_idx_o  = '0;
        for (int i = 0; i < N; i++)
        begin
            if (pend_i[i] && (prio_i[i*8 +: 8] > win_prio_o))
            begin
                win_prio_o = prio_i[i*8 +: 8];
                win_idx_o  = IW'(i);
            end
        end
    end

endmodule : cipg_arb

`default_nettype wire

// ### rtl/cipg_top.sv
// Purpose: interrupt acceptance gate with AHB-Lite register access
// Assumes: single clock, core pulses rfe_i and holds cpu_ready_i
// Notes:   one saved context level; deeper nesting saves it in software
//
// Local design decisions: the address map and register access over AHB-Lite.
`include "cipg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cipg_top
    import cipg_pkg::*;
#(
    parameter int NHW = 4,
    parameter int NSW = `CIPG_NUM_SW_NODES
)
(
    input  wire logic           mclk_i,
    input  wire logic           rstn_i,
    input  wire logic           hsel_i,
    input  wire logic [31:0]    haddr_i,
    input  wire logic [1:0]     htrans_i,
    input  wire logic           hwrite_i,
    input  wire logic [2:0]     hsize_i,
    input  wire logic [31:0]    hwdata_i,
    input  wire logic           hready_i,
    output logic [31:0]         hrdata_o,
    output logic                hreadyout_o,
    output logic                hresp_o,
    input  wire logic [NHW-1:0] hw_req_i,
    input  wire logic           cpu_ready_i,
    input  wire logic           rfe_i,
    output logic                take_o,
    output logic [31:0]         vector_o,
    output cipg_prio_t          take_prio_o,
    output logic                ie_o,
    output cipg_prio_t          current_cpu_priority_o
);

    localparam int N  = NHW + NSW;
    localparam int IW = (N > 1) ? $clog2(N) : 1;

    // ======================================================
    // state
    typedef struct packed {
        cipg_arb_e     arb;
        logic [N-1:0]  seen;
        cipg_prio_t    pending_priority_number;
        logic [IW-1:0] widx;
        logic          ie;
        cipg_prio_t    current_cpu_priority;
        logic [31:0]   base;
        cipg_prio_t    spp;
        logic          spie;
        logic          take;
        logic [31:0]   vec;
        cipg_prio_t    tprio;
        logic          wr;
        logic [7:0]    waddr;
        logic [31:0]   rdata;
    } cipg_top_s;

    cipg_top_s       st_q;
    cipg_top_s       st_d;
    logic [N-1:0]    req_w;
    logic [N-1:0]    en_w;
    logic [N*8-1:0]  prio_w;
    logic [N-1:0]    pend_w;
    logic [N-1:0]    node_wr_w;
    logic [N-1:0]    take_clr_w;
    logic [N-1:0]    hw_set_w;
    cipg_prio_t      win_prio_w;
    logic [IW-1:0]   win_idx_w;
    logic            aphase_w;
    logic            ctrl_wr_w;
    logic            node_touch_w;
    logic            take_now_w;

    // ======================================================
    // nodes: hardware ones first, software-only ones after
    assign hw_set_w = {{NSW{1'b0}}, hw_req_i};

    for (genvar g = 0; g < N; g++)
    begin : g_node
        cipg_node u_node (
            .mclk_i     (mclk_i),
            .rstn_i     (rstn_i),
            .hw_set_i   (hw_set_w[g]),
            .take_clr_i (take_clr_w[g]),
            .wr_i       (node_wr_w[g]),
            .wdata_i    (hwdata_i),
            .prio_o     (prio_w[g*8 +: 8]),
            .en_o       (en_w[g]),
            .req_o      (req_w[g])
        );
        assign pend_w[g] = req_w[g] & en_w[g]
                         & (prio_w[g*8 +: 8] != `CIPG_PRIO_NONE);
        assign node_wr_w[g] = st_q.wr
                            && (st_q.waddr == 8'(`CIPG_OFS_NODE0 + 4 * g));
        assign take_clr_w[g] = take_now_w && (st_q.widx == IW'(g));
    end

    cipg_arb #(
        .N  (N),
        .IW (IW)
    ) u_arb (
        .pend_i     (pend_w),
        .prio_i     (prio_w),
        .win_prio_o (win_prio_w),
        .win_idx_o  (win_idx_w)
    );

    // ======================================================
    // bus decode
    assign aphase_w     = hsel_i & hready_i & htrans_i[1];
    assign ctrl_wr_w    = st_q.wr && (st_q.waddr == `CIPG_OFS_CTRL);
    assign node_touch_w = |node_wr_w;

    // core blocked while a control write or return is in flight
    assign take_now_w = (st_q.arb == ARB_IDLE)
                     && (st_q.pending_priority_number != `CIPG_PRIO_NONE)
                     && st_q.ie
                     && (st_q.pending_priority_number > st_q.current_cpu_priority)
                     && cpu_ready_i && !ctrl_wr_w && !rfe_i;

    function automatic logic [31:0] rd_mux(input logic [7:0] a, input cipg_top_s s);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == `CIPG_OFS_CTRL)
        begin
            r[7:0]                                   = s.current_cpu_priority;
            r[`CIPG_CTRL_IE_BIT]                     = s.ie;
            r[`CIPG_CTRL_PENDING_PRIORITY_NUMBER_LSB +: 8]              = s.pending_priority_number;
        end
        else if (a == `CIPG_OFS_BASE)
            r = s.base;
        else if (a == `CIPG_OFS_SAVED)
        begin
            r[7:0]                 = s.spp;
            r[`CIPG_SAVED_PIE_BIT] = s.spie;
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                if (a == 8'(`CIPG_OFS_NODE0 + 4 * i))
                begin
                    r[7:0]                  = prio_w[i*8 +: 8];
                    r[`CIPG_NODE_EN_BIT]    = en_w[i];
                    r[`CIPG_NODE_REQ_BIT]   = req_w[i];
                end
            end
        end
        return r;
    endfunction : rd_mux

    // ======================================================
    // next state
    always_comb
    begin
        st_d      = st_q;
        st_d.take = 1'b0;
        st_d.wr   = aphase_w & hwrite_i;
        if (aphase_w)
            st_d.waddr = haddr_i[7:0];
        if (aphase_w && !hwrite_i)
            st_d.rdata = rd_mux(haddr_i[7:0], st_q);

        // software writes in the data phase
        if (ctrl_wr_w)
        begin
            st_d.current_cpu_priority = hwdata_i[7:0];
            st_d.ie   = hwdata_i[`CIPG_CTRL_IE_BIT];
        end
        if (st_q.wr && (st_q.waddr == `CIPG_OFS_BASE))
            st_d.base = hwdata_i & `CIPG_BASE_MASK;
        if (st_q.wr && (st_q.waddr == `CIPG_OFS_SAVED))
        begin
            st_d.spp  = hwdata_i[7:0];
            st_d.spie = hwdata_i[`CIPG_SAVED_PIE_BIT];
        end

        // arbitration restarts on any change of the pending set
        case (st_q.arb)
            ARB_IDLE:
            begin
                if ((pend_w != st_q.seen) || node_touch_w)
                    st_d.arb = ARB_CLEAR;
            end
            ARB_CLEAR:
            begin
                st_d.pending_priority_number = `CIPG_PRIO_NONE;
                st_d.seen = pend_w;
                st_d.arb  = ARB_LOAD;
            end
            ARB_LOAD:
            begin
                st_d.pending_priority_number = win_prio_w;
                st_d.widx = win_idx_w;
                st_d.arb  = ARB_IDLE;
            end
            default:
                st_d.arb = ARB_IDLE;
        endcase

        if (take_now_w)
        begin
            st_d.ie    = 1'b0;
            st_d.spie  = st_q.ie;
            st_d.spp   = st_q.current_cpu_priority;
            st_d.current_cpu_priority  = st_q.pending_priority_number;
            st_d.tprio = st_q.pending_priority_number;
            st_d.vec   = ({24'h00_0000, st_q.pending_priority_number} << `CIPG_VEC_SHIFT)
                       | st_q.base;
            st_d.take  = 1'b1;
        end
        else if (rfe_i)
        begin
            st_d.current_cpu_priority = st_q.spp;
            st_d.ie   = st_q.spie;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            st_q      <= '0;
            st_q.arb  <= ARB_IDLE;
            st_q.base <= `CIPG_BASE_RESET;
        end
        else
            st_q <= st_d;
    end

    // ======================================================
    // outputs
    assign hrdata_o    = st_q.rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;
    assign take_o      = st_q.take;
    assign vector_o    = st_q.vec;
    assign take_prio_o = st_q.tprio;
    assign ie_o        = st_q.ie;
    assign current_cpu_priority_o      = st_q.current_cpu_priority;

    // ======================================================
    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_entry;
        take_now_w ##1 take_o;
    endsequence

    property p_entry;
        take_now_w |=> take_o && !st_q.ie && (st_q.current_cpu_priority == $past(st_q.pending_priority_number));
    endproperty
    a_entry: assert property (p_entry) else $error("entry state wrong");

    property p_hold_off;
        s_entry |=> !take_o;
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("double take");

    property p_return;
        (rfe_i && !take_now_w) |=> (st_q.ie == $past(st_q.spie))
                                   && (st_q.current_cpu_priority == $past(st_q.spp));
    endproperty
    a_return: assert property (p_return) else $error("return restore wrong");

    property p_above_only;
        take_o |-> $past(st_q.pending_priority_number) > $past(st_q.current_cpu_priority) && $past(st_q.ie);
    endproperty
    a_above_only: assert property (p_above_only) else $error("take not above");

    property p_take_when_due;
        (st_q.arb == ARB_IDLE && st_q.ie && st_q.pending_priority_number > st_q.current_cpu_priority && cpu_ready_i
         && !ctrl_wr_w && !rfe_i) |=> take_o;
    endproperty
    a_take_when_due: assert property (p_take_when_due) else $error("due take missed");

    property p_max_blocks;
        (st_q.current_cpu_priority == `CIPG_PRIO_MAX) |-> ##1 !take_o;
    endproperty
    a_max_blocks: assert property (p_max_blocks) else $error("255 not blocking");

    property p_vector;
        take_o |-> vector_o == (({24'h00_0000, take_prio_o} << `CIPG_VEC_SHIFT) | st_q.base);
    endproperty
    a_vector: assert property (p_vector) else $error("vector address wrong");

    property p_arb_clear;
        (st_q.arb == ARB_CLEAR) |=> (st_q.pending_priority_number == `CIPG_PRIO_NONE) ##1 (st_q.arb == ARB_IDLE);
    endproperty
    a_arb_clear: assert property (p_arb_clear) else $error("arbitration start wrong");

    property p_save;
        take_now_w |=> (st_q.spie == $past(st_q.ie)) && (st_q.spp == $past(st_q.current_cpu_priority));
    endproperty
    a_save: assert property (p_save) else $error("context not saved");

    property p_winner;
        (st_q.arb == ARB_LOAD) |=> st_q.pending_priority_number == $past(win_prio_w);
    endproperty
    a_winner: assert property (p_winner) else $error("winner not loaded");

    property p_lowest;
        take_o |-> take_prio_o >= 8'h01;
    endproperty
    a_lowest: assert property (p_lowest) else $error("priority zero taken");

endmodule : cipg_top

`default_nettype wire

// ### sim/cipg_core_model.sv
// Purpose: core and peripheral side seen by the priority gate
// Assumes: tasks are entered just after a rising edge
// Notes:   slow mode stalls ready at random, delaying entry
`timescale 1ns/1ps
`default_nettype none

module cipg_core_model
#(
    parameter int NHW = 4
)
(
    input  wire logic      mclk_i,
    input  wire logic      slow_i,
    output logic           cpu_ready_o,
    output logic           rfe_o,
    output logic [NHW-1:0] hw_req_o
);
    initial
    begin
        cpu_ready_o = 1'b1;
        rfe_o       = 1'b0;
        hw_req_o    = '0;
    end

    // ==========================================================
    // ready: a busy core may refuse entry for a few cycles
    always @(posedge mclk_i)
        cpu_ready_o <= !slow_i || ($urandom_range(3, 0) == 0);

    // ==========================================================
    // return pulse, one cycle, as the core issues it
    task automatic do_rfe();
        rfe_o <= 1'b1;
        @(posedge mclk_i);
        rfe_o <= 1'b0;
        @(posedge mclk_i);
    endtask : do_rfe

    // peripheral event, one-cycle pulse
    task automatic post_hw(input int k);
        hw_req_o[k] <= 1'b1;
        @(posedge mclk_i);
        hw_req_o <= '0;
        @(posedge mclk_i);
    endtask : post_hw
endmodule : cipg_core_model
`default_nettype wire

// ### sim/cipg_top_test.sv
// Purpose: self-checking bench for the priority gate
// Assumes: zero-wait register bus, one saved context level
// Notes:   takes are queued as expectations, checked at the falling edge
`include "cipg_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cipg_top_test
    import cipg_pkg::*;
;
    logic        mclk_i, rstn_i, hsel, hwrite, slow;
    logic        cpu_ready, return_from_exception, take, hreadyout, hresp, ie;
    logic [31:0] haddr, hwdata, hrdata, vector, base;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  hw_req;
    cipg_prio_t  take_prio, current_cpu_priority;
    logic [39:0] exp_q[$];
    logic [39:0] e;
    int          err_count, n_tests;

    initial
    begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    cipg_top #(.NHW(4)) dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
        .hreadyout_o(hreadyout), .hresp_o(hresp), .hw_req_i(hw_req),
        .cpu_ready_i(cpu_ready), .rfe_i(return_from_exception), .take_o(take), .vector_o(vector),
        .take_prio_o(take_prio), .ie_o(ie), .current_cpu_priority_o(current_cpu_priority));

    cipg_core_model #(.NHW(4)) core (.mclk_i(mclk_i), .slow_i(slow),
        .cpu_ready_o(cpu_ready), .rfe_o(return_from_exception), .hw_req_o(hw_req));

    // ==========================================================
    // helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'h2;
        do @(posedge mclk_i); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'($urandom);
        hsize  <= 3'($urandom);
        hwdata <= wd;
        do @(posedge mclk_i); while (hreadyout !== 1'b1);
        rd = hrdata;
        check(32'(hresp), 32'h0, "okay response");
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input string what);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(r, x, what);
    endtask : rd_chk

    function automatic logic [7:0] node(input int i);
        return `CIPG_OFS_NODE0 + 8'(4 * i);
    endfunction : node

    // entry address: base ORed with priority shifted five, 32 bytes apart
    task automatic expect_take(input cipg_prio_t p);
        exp_q.push_back({base | (32'(p) << 5), p});
    endtask : expect_take

    task automatic wait_takes();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 300)
        begin
            @(posedge mclk_i);
            n++;
        end
        check(32'(exp_q.size()), 32'h0, "take missing");
        @(posedge mclk_i);
    endtask : wait_takes

    task automatic quiet(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : quiet

    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    // ==========================================================
    // monitor: a take with no note means a blocked request got through
    always @(negedge mclk_i)
        if (take === 1'b1)
        begin
            n_tests++;
            if (exp_q.size() == 0)
            begin
                err_count++;
                $display("wrong value at %0t: unexpected take %h", $time, take_prio);
            end
            else
            begin
                e = exp_q.pop_front();
                if ({vector, take_prio} !== e)
                begin
                    err_count++;
                    $display("wrong value at %0t: take %h %h", $time, vector, take_prio);
                end
            end
        end

    initial
    begin
        #(4000 * 25);
        err_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        complete_run();
    end

    // ==========================================================
    // main sequence; no node uses a number inside a spanned entry
    initial
    begin
        int p;
        void'($urandom(32'hc6be));
        {hsel, hwrite, slow} = '0;
        haddr = '0; hwdata = '0; htrans = '0; hsize = 3'h2; base = '0;
        err_count = 0; n_tests = 0;
        rstn_i = 1'b0;
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        check(32'({hreadyout, ie, current_cpu_priority}), 32'h200, "reset outputs");
        rd_chk(`CIPG_OFS_CTRL, 32'h0, "ctrl reset");
        wr(8'h40, 32'hffff_ffff);
        rd_chk(8'h40, 32'h0, "unmapped");
        wr(`CIPG_OFS_BASE, 32'h0000_2001);
        rd_chk(`CIPG_OFS_BASE, 32'h0000_2000, "base bit0");
        base = 32'h0000_2000;
        // hardware request, then lowered repost from inside the routine
        wr(`CIPG_OFS_CTRL, 32'h100);
        wr(node(0), 32'h405);
        expect_take(8'd5);
        core.post_hw(0);
        wait_takes();
        check(32'({ie, current_cpu_priority}), 32'h005, "entry state");
        rd_chk(`CIPG_OFS_SAVED, 32'h100, "saved context");
        wr(node(0), 32'h0400_0401);
        wr(node(4), 32'h0400_0409);
        quiet(20);
        rd_chk(`CIPG_OFS_CTRL, 32'h0009_0005, "pending number");
        rd_chk(node(4), 32'h0100_0409, "request flag");
        expect_take(8'd9);
        core.do_rfe();
        wait_takes();
        expect_take(8'd1);
        core.do_rfe();
        wait_takes();
        core.do_rfe();
        quiet(5);
        check(32'({ie, current_cpu_priority}), 32'h100, "return state");
        // equal and lower blocked, higher taken mid-routine
        wr(node(1), 32'h409);
        wr(node(2), 32'h403);
        wr(node(3), 32'h40c);
        wr(`CIPG_OFS_CTRL, 32'h109);
        core.post_hw(1);
        core.post_hw(2);
        quiet(20);
        expect_take(8'd12);
        core.post_hw(3);
        wait_takes();
        rd_chk(`CIPG_OFS_SAVED, 32'h109, "saved nested");
        core.do_rfe();
        quiet(10);
        check(32'({ie, current_cpu_priority}), 32'h109, "restored level");
        expect_take(8'd9);
        wr(`CIPG_OFS_CTRL, 32'h102);
        wait_takes();
        expect_take(8'd3);
        core.do_rfe();
        wait_takes();
        core.do_rfe();
        quiet(5);
        check(32'({ie, current_cpu_priority}), 32'h102, "after drain");
        // top priority level blocks even 254
        wr(`CIPG_OFS_CTRL, 32'h1ff);
        wr(node(5), 32'h0400_04fe);
        quiet(20);
        expect_take(8'd254);
        wr(`CIPG_OFS_CTRL, 32'h100);
        wait_takes();
        core.do_rfe();
        quiet(3);
        // software clear of a posted flag, polled while disabled
        wr(`CIPG_OFS_CTRL, 32'h000);
        wr(node(6), 32'h0400_0420);
        quiet(5);
        rd_chk(`CIPG_OFS_CTRL, 32'h0020_0000, "polled pending");
        wr(node(6), 32'h0200_0420);
        quiet(5);
        rd_chk(node(6), 32'h0000_0420, "flag cleared");
        rd_chk(`CIPG_OFS_CTRL, 32'h0000_0000, "nothing pending");
        wr(`CIPG_OFS_CTRL, 32'h100);
        quiet(10);
        // software-only nodes, random numbers, slow core
        slow <= 1'b1;
        for (int i = 4; i < 8; i++)
        begin
            p = $urandom_range(254, 1);
            expect_take(8'(p));
            wr(node(i), 32'h0400_0400 | 32'(p));
            wait_takes();
            check(32'({ie, current_cpu_priority}), 32'(p), "random entry");
            core.do_rfe();
            quiet(3);
        end
        quiet(20);
        complete_run();
    end
endmodule : cipg_top_test
`default_nettype wire
